// file: core/lsi_pkg.sv
`default_nettype none
package lsi_pkg;
  localparam int         NUM_CH        = 4;
  localparam int         AW            = 12;
  // Register indices within one channel; byte address is four times the index
  localparam logic [7:0] CH_STRIDE     = 8'h40;
  localparam logic [5:0] IDX_STATUS    = 6'h15;
  localparam logic [5:0] IDX_EVENT     = 6'h16;
  localparam logic [5:0] IDX_EVMASK    = 6'h08;
  localparam logic [5:0] IDX_EDGE      = 6'h09;
  localparam logic [5:0] IDX_IRQEN     = 6'h0A;
  // Field positions
  localparam int         BIT_RLOOP     = 5;
  localparam int         ATT_W         = 5;
  localparam int         BIT_TCLK      = 3;
  // Values after reset
  localparam logic [7:0] EVMASK_RST    = 8'hFF;
  localparam logic [7:0] EDGE_RST      = 8'h00;
  localparam logic [7:0] IRQEN_RST     = 8'h00;
  localparam logic [7:0] FLAGS_RST     = 8'h00;
  // Transmit clock loss threshold, master clock cycles (70)
  localparam logic [6:0] TCLK_LOSS_CYC = 7'h46;
  localparam logic [1:0] RESP_OKAY     = 2'h0;
  localparam logic [1:0] RESP_SLVERR   = 2'h2;

  typedef enum logic [2:0] {
    SEL_NONE   = 3'b000,
    SEL_STATUS = 3'b001,
    SEL_EVENT  = 3'b010,
    SEL_EVMASK = 3'b011,
    SEL_EDGE   = 3'b100,
    SEL_IRQEN  = 3'b101
  } lsi_sel_t;

  // Address bits [9:8] pick the channel, so channel copies sit CH_STRIDE indices apart
  function automatic lsi_sel_t lsi_sel_of(input logic [AW-1:0] a);
    lsi_sel_t s;
    s = SEL_NONE;
    if (a[11:10] == 2'h0) begin
      case (a[7:2])
        IDX_STATUS: s = SEL_STATUS;
        IDX_EVENT:  s = SEL_EVENT;
        IDX_EVMASK: s = SEL_EVMASK;
        IDX_EDGE:   s = SEL_EDGE;
        IDX_IRQEN:  s = SEL_IRQEN;
        default:    s = SEL_NONE;
      endcase
    end
    return s;
  endfunction
endpackage
`default_nettype wire

// file: core/lsi_evt_if.sv
`timescale 1ns/1ps
`default_nettype none
interface lsi_evt_if;
  logic [7:0] status;
  logic [7:0] mask;
  logic [7:0] edge_sel;
  logic [7:0] event_p;
  modport det (input status, input mask, input edge_sel, output event_p);
  modport ctl (output status, output mask, output edge_sel, input event_p);
endinterface // lsi_evt_if
`default_nettype wire

// file: core/lsi_evt_det.sv
`timescale 1ns/1ps
`default_nettype none
module lsi_evt_det (
  input wire logic aclk,
  input wire logic aresetn,
  lsi_evt_if.det   bus
);
  logic [7:0] prev_q;
  logic [7:0] prev_d;

  always_comb begin
    prev_d = bus.status;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      prev_q <= 8'h00;
    end else begin
      prev_q <= prev_d;
    end
  end

  // Only unmasked bits raise events; edge select widens rising to any change
  assign bus.event_p = ~bus.mask & ((bus.edge_sel & (prev_q ^ bus.status)) |
                                    (~bus.edge_sel & ~prev_q & bus.status));

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_masked_quiet;
    (bus.mask & bus.event_p) == 8'h00;
  endproperty
  a_masked_quiet: assert property (p_masked_quiet) else $error("masked bit raised event");

  property p_fall_edge;
    (!bus.mask[0] && $fell(bus.status[0])) |-> (bus.event_p[0] == bus.edge_sel[0]);
  endproperty
  a_fall_edge: assert property (p_fall_edge) else $error("falling edge event wrong");

  property p_rise_edge;
    (!bus.mask[1] && $rose(bus.status[1])) |-> bus.event_p[1];
  endproperty
  a_rise_edge: assert property (p_rise_edge) else $error("rising edge event lost");
endmodule // lsi_evt_det
`default_nettype wire

// file: core/lsi_tclk_mon.sv
`timescale 1ns/1ps
`default_nettype none
module lsi_tclk_mon (
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic tclk,
  output logic      loss
);
  logic       prev_q;
  logic       prev_d;
  logic [6:0] cnt_q;
  logic [6:0] cnt_d;
  logic       loss_q;
  logic       loss_d;
  logic [7:0] h_q;

  // Counter saturates just past the threshold so it never wraps
  always_comb begin
    prev_d = tclk;
    cnt_d  = cnt_q;
    if (tclk != prev_q) begin
      cnt_d = 7'h00;
    end else if (cnt_q <= lsi_pkg::TCLK_LOSS_CYC) begin
      cnt_d = cnt_q + 7'h01;
    end
    loss_d = (cnt_d > lsi_pkg::TCLK_LOSS_CYC);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      prev_q <= 1'b0;
      cnt_q  <= 7'h00;
      loss_q <= 1'b0;
    end else begin
      prev_q <= prev_d;
      cnt_q  <= cnt_d;
      loss_q <= loss_d;
    end
  end

  assign loss = loss_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      h_q <= 8'h00;
    end else if ($changed(tclk)) begin
      h_q <= 8'h00;
    end else if (h_q != 8'hFF) begin
      h_q <= h_q + 8'h01;
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_loss_time;
    loss_q == (h_q > {1'b0, lsi_pkg::TCLK_LOSS_CYC});
  endproperty
  a_loss_time: assert property (p_loss_time) else $error("clock loss timing wrong");
endmodule // lsi_tclk_mon
`default_nettype wire

// file: core/lsi_top.sv
// Overview of operation
// - Both registers repeat per channel, 0x40 apart
// - Status bit 5 shows remote loopback closed
// - Status bits 4-0 give attenuation code
// - Reading event register clears its flags
// - Event bit 7: equalizer out of range
// - Event bit 6: inband loopback activate code
// - Event bit 5: inband loopback deactivate code
// - Event bit 4: pattern sync status change
// - Event bit 3: transmit clock loss
// - Event bit 2: line driver failure
// - Event bit 1: alarm indication signal
// - Event bit 0: loss of signal
// - Unmasked events only; edge select picks edges
// - Clock loss after 70 quiet cycles
//
// Added by the designer: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module lsi_top (
  input  wire logic                      aclk,
  input  wire logic                      aresetn,
  input  wire logic [lsi_pkg::AW-1:0]    awaddr,
  input  wire logic                      awvalid,
  output logic                           awready,
  input  wire logic [31:0]               wdata,
  input  wire logic [3:0]                wstrb,
  input  wire logic                      wvalid,
  output logic                           wready,
  output logic [1:0]                     bresp,
  output logic                           bvalid,
  input  wire logic                      bready,
  input  wire logic [lsi_pkg::AW-1:0]    araddr,
  input  wire logic                      arvalid,
  output logic                           arready,
  output logic [31:0]                    rdata,
  output logic [1:0]                     rresp,
  output logic                           rvalid,
  input  wire logic                      rready,
  input  wire logic [8*lsi_pkg::NUM_CH-1:0] status_raw,
  input  wire logic [lsi_pkg::NUM_CH-1:0]   remote_loop_active,
  input  wire logic [5*lsi_pkg::NUM_CH-1:0] line_attenuation_code,
  input  wire logic [lsi_pkg::NUM_CH-1:0]   channel_tx_clock,
  output logic                           irq
);
  localparam int NCH = lsi_pkg::NUM_CH;

  logic                   aw_full_q;
  logic                   aw_full_d;
  logic [lsi_pkg::AW-1:0] awaddr_q;
  logic [lsi_pkg::AW-1:0] awaddr_d;
  logic                   w_full_q;
  logic                   w_full_d;
  logic [7:0]             wdata_q;
  logic [7:0]             wdata_d;
  logic                   wstrb0_q;
  logic                   wstrb0_d;
  logic                   awready_q;
  logic                   awready_d;
  logic                   wready_q;
  logic                   wready_d;
  logic                   bvalid_q;
  logic                   bvalid_d;
  logic [1:0]             bresp_q;
  logic [1:0]             bresp_d;
  logic                   arready_q;
  logic                   arready_d;
  logic                   rvalid_q;
  logic                   rvalid_d;
  logic [31:0]            rdata_q;
  logic [31:0]            rdata_d;
  logic [1:0]             rresp_q;
  logic [1:0]             rresp_d;
  logic                   irq_q;
  logic                   irq_d;

  logic                   wr_fire;
  logic                   rd_fire;
  lsi_pkg::lsi_sel_t      wsel;
  lsi_pkg::lsi_sel_t      rsel;
  logic [1:0]             wch;
  logic [1:0]             rch;

  logic [NCH-1:0][7:0]    flags_q;
  logic [NCH-1:0][7:0]    flags_d;
  logic [NCH-1:0][7:0]    evmask_q;
  logic [NCH-1:0][7:0]    evmask_d;
  logic [NCH-1:0][7:0]    edge_q;
  logic [NCH-1:0][7:0]    edge_d;
  logic [NCH-1:0][7:0]    irqen_q;
  logic [NCH-1:0][7:0]    irqen_d;
  logic [NCH-1:0][7:0]    stat_q;
  logic [NCH-1:0][7:0]    stat_d;
  logic [NCH-1:0][7:0]    clr;
  logic [NCH-1:0][7:0]    evt;
  logic [NCH-1:0]         tclk_loss;

  lsi_evt_if evt_bus [NCH] ();

  for (genvar ch = 0; ch < NCH; ch++) begin : g_ch
    lsi_tclk_mon u_mon (
      .aclk    (aclk),
      .aresetn (aresetn),
      .tclk    (channel_tx_clock[ch]),
      .loss    (tclk_loss[ch])
    );
    // Status bit 3 comes from the local clock monitor; status_raw bit 3 is not used
    assign evt_bus[ch].status   = {status_raw[8*ch+4 +: 4], tclk_loss[ch],
                                   status_raw[8*ch +: 3]};
    assign evt_bus[ch].mask     = evmask_q[ch];
    assign evt_bus[ch].edge_sel = edge_q[ch];
    assign evt[ch]              = evt_bus[ch].event_p;
    lsi_evt_det u_det (
      .aclk    (aclk),
      .aresetn (aresetn),
      .bus     (evt_bus[ch])
    );
  end

  assign wsel = lsi_pkg::lsi_sel_of(awaddr_q);
  assign wch  = awaddr_q[9:8];
  assign rsel = lsi_pkg::lsi_sel_of(araddr);
  assign rch  = araddr[9:8];

  // Bus channels: write address and data may arrive in either order
  always_comb begin
    aw_full_d = aw_full_q;
    awaddr_d  = awaddr_q;
    w_full_d  = w_full_q;
    wdata_d   = wdata_q;
    wstrb0_d  = wstrb0_q;
    bvalid_d  = bvalid_q;
    bresp_d   = bresp_q;
    rvalid_d  = rvalid_q;
    rdata_d   = rdata_q;
    rresp_d   = rresp_q;
    wr_fire   = 1'b0;
    rd_fire   = 1'b0;
    if (awvalid && awready_q) begin
      aw_full_d = 1'b1;
      awaddr_d  = awaddr;
    end
    if (wvalid && wready_q) begin
      w_full_d = 1'b1;
      wdata_d  = wdata[7:0];
      wstrb0_d = wstrb[0];
    end
    if (bvalid_q && bready) begin
      bvalid_d = 1'b0;
    end
    if (aw_full_q && w_full_q && !bvalid_q) begin
      wr_fire   = 1'b1;
      aw_full_d = 1'b0;
      w_full_d  = 1'b0;
      bvalid_d  = 1'b1;
      bresp_d   = (wsel == lsi_pkg::SEL_NONE) ? lsi_pkg::RESP_SLVERR : lsi_pkg::RESP_OKAY;
    end
    awready_d = !aw_full_d && !bvalid_d;
    wready_d  = !w_full_d && !bvalid_d;
    if (rvalid_q && rready) begin
      rvalid_d = 1'b0;
    end
    if (arvalid && arready_q) begin
      rd_fire  = 1'b1;
      rvalid_d = 1'b1;
      rresp_d  = lsi_pkg::RESP_OKAY;
      case (rsel)
        lsi_pkg::SEL_STATUS: rdata_d = {24'h00_0000, stat_q[rch]};
        lsi_pkg::SEL_EVENT:  rdata_d = {24'h00_0000, flags_q[rch]};
        lsi_pkg::SEL_EVMASK: rdata_d = {24'h00_0000, evmask_q[rch]};
        lsi_pkg::SEL_EDGE:   rdata_d = {24'h00_0000, edge_q[rch]};
        lsi_pkg::SEL_IRQEN:  rdata_d = {24'h00_0000, irqen_q[rch]};
        default: begin
          rdata_d = 32'h0000_0000;
          rresp_d = lsi_pkg::RESP_SLVERR;
        end
      endcase
    end
    arready_d = !rvalid_d;
  end

  // Register file, flags and interrupt
  always_comb begin
    flags_d  = flags_q;
    evmask_d = evmask_q;
    edge_d   = edge_q;
    irqen_d  = irqen_q;
    stat_d   = stat_q;
    clr      = '0;
    for (int ch = 0; ch < NCH; ch++) begin
      stat_d[ch] = 8'h00;
      stat_d[ch][lsi_pkg::BIT_RLOOP] = remote_loop_active[ch];
      stat_d[ch][lsi_pkg::ATT_W-1:0] = line_attenuation_code[5*ch +: 5];
      if (rd_fire && rsel == lsi_pkg::SEL_EVENT && rch == 2'(ch)) begin
        clr[ch] = 8'hFF;
      end
      if (wr_fire && wstrb0_q && wch == 2'(ch)) begin
        case (wsel)
          lsi_pkg::SEL_EVENT:  clr[ch] = clr[ch] | wdata_q;
          lsi_pkg::SEL_EVMASK: evmask_d[ch] = wdata_q;
          lsi_pkg::SEL_EDGE:   edge_d[ch] = wdata_q;
          lsi_pkg::SEL_IRQEN:  irqen_d[ch] = wdata_q;
          default: begin
          end
        endcase
      end
      // A new event beats a clear in the same cycle
      flags_d[ch] = (flags_q[ch] & ~clr[ch]) | evt[ch];
    end
    irq_d = |(flags_d & irqen_d);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_q <= 1'b0;
      awaddr_q  <= '0;
      w_full_q  <= 1'b0;
      wdata_q   <= 8'h00;
      wstrb0_q  <= 1'b0;
      awready_q <= 1'b0;
      wready_q  <= 1'b0;
      bvalid_q  <= 1'b0;
      bresp_q   <= lsi_pkg::RESP_OKAY;
      arready_q <= 1'b0;
      rvalid_q  <= 1'b0;
      rdata_q   <= 32'h0000_0000;
      rresp_q   <= lsi_pkg::RESP_OKAY;
      irq_q     <= 1'b0;
      flags_q   <= {NCH{lsi_pkg::FLAGS_RST}};
      evmask_q  <= {NCH{lsi_pkg::EVMASK_RST}};
      edge_q    <= {NCH{lsi_pkg::EDGE_RST}};
      irqen_q   <= {NCH{lsi_pkg::IRQEN_RST}};
      stat_q    <= '0;
    end else begin
      aw_full_q <= aw_full_d;
      awaddr_q  <= awaddr_d;
      w_full_q  <= w_full_d;
      wdata_q   <= wdata_d;
      wstrb0_q  <= wstrb0_d;
      awready_q <= awready_d;
      wready_q  <= wready_d;
      bvalid_q  <= bvalid_d;
      bresp_q   <= bresp_d;
      arready_q <= arready_d;
      rvalid_q  <= rvalid_d;
      rdata_q   <= rdata_d;
      rresp_q   <= rresp_d;
      irq_q     <= irq_d;
      flags_q   <= flags_d;
      evmask_q  <= evmask_d;
      edge_q    <= edge_d;
      irqen_q   <= irqen_d;
      stat_q    <= stat_d;
    end
  end

  assign awready = awready_q;
  assign wready  = wready_q;
  assign bvalid  = bvalid_q;
  assign bresp   = bresp_q;
  assign arready = arready_q;
  assign rvalid  = rvalid_q;
  assign rdata   = rdata_q;
  assign rresp   = rresp_q;
  assign irq     = irq_q;

  localparam logic [11:0] A_LINE_STATUS_LOOPBACK_ATTENUATION = {2'h0, lsi_pkg::CH_STRIDE[1:0] + 2'h0,
                                     lsi_pkg::IDX_STATUS, 2'h0};
  localparam logic [11:0] A_EV0   = {4'h0, lsi_pkg::IDX_EVENT, 2'h0};

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_stat_copy;
    (rd_fire && araddr == (A_LINE_STATUS_LOOPBACK_ATTENUATION | 12'h100)) |=>
      (rdata_q[7:0] == $past(stat_q[1]) && rdata_q[7:6] == 2'h0);
  endproperty
  a_stat_copy: assert property (p_stat_copy) else $error("channel 1 status misplaced");

  property p_rloop;
    (rd_fire && araddr == {4'h0, lsi_pkg::IDX_STATUS, 2'h0}) |=>
      rdata_q[5] == $past(remote_loop_active[0], 2);
  endproperty
  a_rloop: assert property (p_rloop) else $error("remote loopback bit wrong");

  property p_att;
    (rd_fire && araddr == {4'h0, lsi_pkg::IDX_STATUS, 2'h0}) |=>
      rdata_q[4:0] == $past(line_attenuation_code[4:0], 2);
  endproperty
  a_att: assert property (p_att) else $error("attenuation code wrong");

  property p_read_clear;
    (rd_fire && araddr == A_EV0 && evt[0] == 8'h00) |=> flags_q[0] == 8'h00;
  endproperty
  a_read_clear: assert property (p_read_clear) else $error("read did not clear flags");

  property p_latch;
    (evt[0] != 8'h00) |=> ((flags_q[0] & $past(evt[0])) == $past(evt[0]));
  endproperty
  a_latch: assert property (p_latch) else $error("event not latched");

  property p_hold;
    (evt[2] == 8'h00 && !rd_fire && !wr_fire) |=> flags_q[2] == $past(flags_q[2]);
  endproperty
  a_hold: assert property (p_hold) else $error("flags changed without cause");

  property p_keep_on_read;
    (rd_fire && araddr == A_EV0 && evt[0][6]) |=> flags_q[0][6] ##1 flags_q[0][6];
  endproperty
  a_keep_on_read: assert property (p_keep_on_read) else $error("event lost on read");

  property p_rd_answer;
    rd_fire |=> rvalid_q && !arready_q;
  endproperty
  a_rd_answer: assert property (p_rd_answer) else $error("read answer missing");

  property p_irq;
    ((flags_q & irqen_q) != '0) |-> irq_q;
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt not raised");
endmodule // lsi_top
`default_nettype wire

// file: verification/lsi_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
module lsi_top_tb;
  logic        aclk, aresetn, irq;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata, status_raw, raw_pend, rd_q;
  logic [3:0]  wstrb, remote_loop_active, channel_tx_clock, tclk_run;
  logic [1:0]  bresp, rresp, rsp;
  logic [19:0] line_attenuation_code;
  logic        raw_apply;
  int          miscompares, compares;
  int          bits[7] = '{7, 6, 5, 4, 2, 1, 0};

  localparam logic [5:0] ix_st = lsi_pkg::IDX_STATUS;
  localparam logic [5:0] ix_ev = lsi_pkg::IDX_EVENT;
  localparam logic [5:0] ix_mk = lsi_pkg::IDX_EVMASK;
  localparam logic [5:0] ix_ed = lsi_pkg::IDX_EDGE;
  localparam logic [5:0] ix_ie = lsi_pkg::IDX_IRQEN;

  lsi_top i_dut (
    .aclk(aclk), .aresetn(aresetn),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .status_raw(status_raw), .remote_loop_active(remote_loop_active),
    .line_attenuation_code(line_attenuation_code),
    .channel_tx_clock(channel_tx_clock), .irq(irq)
  );

  initial begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end

  // Transmit clocks toggle every cycle while enabled; stopping one starves its monitor
  always @(posedge aclk) begin
    channel_tx_clock <= channel_tx_clock ^ tclk_run;
  end

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask

  function automatic logic [11:0] ra(input int ch, input logic [5:0] idx);
    return {2'b00, ch[1:0], idx, 2'b00};
  endfunction

  task automatic axi_write(input logic [11:0] a, input logic [7:0] d, output logic [1:0] r,
                           input logic [3:0] s = 4'hf);
    bit ta = 1'b0;
    bit tw = 1'b0;
    @(posedge aclk);
    awaddr  <= a;
    awvalid <= 1'b1;
    wdata   <= {24'h00_0000, d};
    wstrb   <= s;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    while (!(ta && tw)) begin
      @(posedge aclk);
      if (!ta && awready) begin
        ta = 1'b1;
        awvalid <= 1'b0;
      end
      if (!tw && wready) begin
        tw = 1'b1;
        wvalid <= 1'b0;
      end
    end
    while (!bvalid) @(posedge aclk);
    r = bresp;
    bready <= 1'b0;
  endtask

  // A pending raw status change is launched on the edge that raises arvalid,
  // so the event lands in the same cycle as the clearing handshake
  task automatic axi_read(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    if (raw_apply) status_raw <= raw_pend;
    raw_apply = 1'b0;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'b0;
    while (!rvalid) @(posedge aclk);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask

  task automatic rdchk(input string n, input logic [11:0] a, input logic [31:0] e,
                       input logic [1:0] er = lsi_pkg::RESP_OKAY);
    axi_read(a, rd_q, rsp);
    check({n, " data"}, rd_q, e);
    check({n, " rresp"}, 32'(rsp), 32'(er));
  endtask

  task automatic wrchk(input string n, input logic [11:0] a, input logic [7:0] d,
                       input logic [1:0] er = lsi_pkg::RESP_OKAY, input logic [3:0] s = 4'hf);
    axi_write(a, d, rsp, s);
    check({n, " bresp"}, 32'(rsp), 32'(er));
  endtask

  // Three edges before anything is read back; detect is combinational, flag and irq both register on the first edge
  task automatic raw_set(input int ch, input int b, input logic v);
    @(posedge aclk);
    status_raw[8*ch+b] <= v;
    repeat (3) @(posedge aclk);
    #1;
  endtask

  task automatic tally_and_finish;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge aclk);
    miscompares++;
    $display("ERROR watchdog expected done seen timeout");
    tally_and_finish;
  end

  initial begin
    aresetn = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready, raw_apply} = '0;
    {awaddr, araddr, wdata, wstrb, status_raw, raw_pend} = '0;
    remote_loop_active = 4'h0;
    line_attenuation_code = 20'h0_0000;
    channel_tx_clock = 4'h0;
    tclk_run = 4'hf;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    rdchk("evmask rst", ra(0, ix_mk), 32'h0000_00ff);
    rdchk("edge rst", ra(0, ix_ed), 32'h0000_0000);
    rdchk("irqen rst", ra(0, ix_ie), 32'h0000_0000);
    rdchk("flags rst", ra(0, ix_ev), 32'h0000_0000);
    for (int k = 0; k < 2; k++) begin
      @(posedge aclk);
      remote_loop_active    <= k ? 4'ha : 4'h5;
      line_attenuation_code <= k ? {5'h00, 5'h0b, 5'h16, 5'h15}
                                 : {5'h1f, 5'h16, 5'h15, 5'h0a};
      repeat (2) @(posedge aclk);
      for (int ch = 0; ch < 4; ch++) begin
        rdchk("status", ra(ch, ix_st),
              32'({remote_loop_active[ch], line_attenuation_code[5*ch+:5]}));
      end
    end
    wrchk("status wr", ra(1, ix_st), 8'hff);
    rdchk("status kept", ra(1, ix_st),
          32'({remote_loop_active[1], line_attenuation_code[9:5]}));
    rdchk("unmapped", 12'h800, 32'h0000_0000, lsi_pkg::RESP_SLVERR);
    wrchk("unmapped wr", 12'h800, 8'h00, lsi_pkg::RESP_SLVERR);
    raw_set(0, 1, 1'b1);
    rdchk("masked", ra(0, ix_ev), 32'h0000_0000);
    raw_set(0, 1, 1'b0);
    wrchk("mask wr", ra(0, ix_mk), 8'h00);
    rdchk("mask rd", ra(0, ix_mk), 32'h0000_0000);
    foreach (bits[i]) begin
      raw_set(0, bits[i], 1'b1);
      rdchk("event", ra(0, ix_ev),
            32'h0000_0001 << bits[i]);
      rdchk("cleared", ra(0, ix_ev), 32'h0000_0000);
      raw_set(0, bits[i], 1'b0);
    end
    rdchk("fall ignored", ra(0, ix_ev), 32'h0000_0000);
    wrchk("mask2 wr", ra(2, ix_mk), 8'h00);
    raw_set(2, 0, 1'b1);
    rdchk("ch2 event", ra(2, ix_ev), 32'h0000_0001);
    rdchk("ch0 quiet", ra(0, ix_ev), 32'h0000_0000);
    wrchk("edge wr", ra(0, ix_ed), 8'h01);
    raw_set(0, 0, 1'b1);
    rdchk("any rise", ra(0, ix_ev), 32'h0000_0001);
    raw_set(0, 0, 1'b0);
    rdchk("any fall", ra(0, ix_ev), 32'h0000_0001);
    wrchk("irqen wr", ra(0, ix_ie), 8'h01);
    // A write with byte lane 0 off must leave the register untouched
    wrchk("strb0 wr", ra(0, ix_ie), 8'hff, lsi_pkg::RESP_OKAY, 4'h0);
    rdchk("strb0 rd", ra(0, ix_ie), 32'h0000_0001);
    raw_set(0, 2, 1'b1);
    check("irq disabled", 32'(irq), 32'h0000_0000);
    wrchk("w1c wr", ra(0, ix_ev), 8'h04);
    rdchk("w1c rd", ra(0, ix_ev), 32'h0000_0000);
    raw_set(0, 0, 1'b1);
    check("irq set", 32'(irq), 32'h0000_0001);
    rdchk("irq flag", ra(0, ix_ev), 32'h0000_0001);
    repeat (2) @(posedge aclk);
    #1;
    check("irq clear", 32'(irq), 32'h0000_0000);
    raw_pend = status_raw | 32'h0000_0040;
    raw_apply = 1'b1;
    axi_read(ra(0, ix_ev), rd_q, rsp);
    check("kept first", rd_q, 32'h0000_0000);
    rdchk("kept on read", ra(0, ix_ev), 32'h0000_0040);
    rdchk("kept cleared", ra(0, ix_ev), 32'h0000_0000);
    @(posedge aclk);
    tclk_run[0] <= 1'b0;
    repeat (60) @(posedge aclk);
    rdchk("tclk early", ra(0, ix_ev), 32'h0000_0000);
    repeat (20) @(posedge aclk);
    rdchk("tclk loss", ra(0, ix_ev), 32'h0000_0008);
    tclk_run[0] <= 1'b1;
    repeat (4) @(posedge aclk);
    tally_and_finish;
  end
endmodule // lsi_top_tb
`default_nettype wire
